/* File: pmd_dispatcher.v */
// packet move dispatcher: pops forwarding decisions, copies or discards one packet each
//
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "pmd_map.vh"
module pmd_dispatcher
(
   input wire pclk,
   input wire presetn,
   input wire pclk_en,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [`PMD_ADDR_W-1:0] paddr,
   input wire [31:0] pwdata,
   output wire [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire decision_queue_empty_flag,
   input wire [`PMD_ENT_W-1:0] decision_entry,
   output reg decision_queue_pop,
   input wire [`PMD_NCH*`PMD_DATA_W-1:0] parser_data_out,
   output wire [`PMD_NCH-1:0] parser_data_read_en,
   output reg [`PMD_NCH*`PMD_LEN_W-1:0] discard_word_count,
   output reg [`PMD_NCH-1:0] discard_strobe,
   input wire [`PMD_NCH-1:0] egress_length_almost_full,
   output reg [`PMD_NCH*`PMD_DATA_W-1:0] egress_data_in,
   output reg [`PMD_NCH-1:0] egress_data_write_en,
   output reg [`PMD_NCH*`PMD_EGR_LEN_W-1:0] egress_length_in,
   output reg [`PMD_NCH-1:0] egress_length_write_en,
   output reg [`PMD_NCH-1:0] source_channel_busy,
   output reg [`PMD_NCH-1:0] target_channel_busy
);
   localparam ST_IDLE = `PMD_ST_IDLE;
   localparam ST_CHECK = `PMD_ST_CHECK;
   localparam ST_START = `PMD_ST_START;
   localparam ST_DISCARD = `PMD_ST_DISCARD;

   reg [1:0] state_q;
   reg [1:0] state_d;
   reg [`PMD_LEN_W-1:0] ent_len_q;
   reg [1:0] ent_src_q;
   reg [`PMD_NCH-1:0] ent_mask_q;
   // which source feeds each target, two bits per target
   reg [2*`PMD_NCH-1:0] owner_q;
   // marks the cycle after a source's final read, when its busy flag drops
   reg [`PMD_NCH-1:0] src_fin_q;
   reg fwd_pulse_q;
   reg disc_pulse_q;

   wire run_en;
   wire [`PMD_NCH-1:0] mv_rd;
   wire [`PMD_NCH-1:0] mv_last;
   wire [`PMD_NCH-1:0] src_onehot = 4'h1 << ent_src_q;
   wire is_discard = (ent_mask_q == 4'h0);
   wire src_free = ~|(source_channel_busy & src_onehot);
   wire tgt_free = ~|(target_channel_busy & ent_mask_q);
   wire tgt_room = ~|(egress_length_almost_full & ent_mask_q);
   wire fwd_go = src_free & tgt_free & tgt_room;
   wire disc_go = src_free;
   wire take_entry = (state_q == ST_IDLE) && run_en && !decision_queue_empty_flag;

   assign parser_data_read_en = mv_rd;

   always @*
   begin
      state_d = state_q;
      case (state_q)
         ST_IDLE:
         begin
            if (take_entry)
               state_d = ST_CHECK;
         end
         ST_CHECK:
         begin
            if (is_discard)
            begin
               if (disc_go)
                  state_d = ST_DISCARD;
            end
            else if (fwd_go)
               state_d = ST_START;
         end
         ST_START:
            state_d = ST_IDLE;
         ST_DISCARD:
            state_d = ST_IDLE;
         default:
            state_d = ST_IDLE;
      endcase
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_q <= ST_IDLE;
         decision_queue_pop <= 1'h0;
         ent_len_q <= 12'h000;
         ent_src_q <= 2'h0;
         ent_mask_q <= 4'h0;
         fwd_pulse_q <= 1'h0;
         disc_pulse_q <= 1'h0;
      end
      else if (pclk_en)
      begin
         state_q <= state_d;
         // entry is visible at the queue head, so it is latched at the pop edge
         decision_queue_pop <= take_entry;
         if (take_entry)
         begin
            ent_len_q <= decision_entry[`PMD_ENT_LEN_MSB:`PMD_ENT_LEN_LSB];
            ent_src_q <= decision_entry[`PMD_ENT_SRC_MSB:`PMD_ENT_SRC_LSB];
            ent_mask_q <= decision_entry[`PMD_ENT_TGT_MSB:`PMD_ENT_TGT_LSB];
         end
         fwd_pulse_q <= (state_q == ST_CHECK) && (state_d == ST_START);
         disc_pulse_q <= (state_q == ST_CHECK) && (state_d == ST_DISCARD);
      end
   end

   genvar ch;
   generate
      for (ch = 0; ch < `PMD_NCH; ch = ch + 1)
      begin : g_chan
         wire [1:0] own = owner_q[2*ch+1:2*ch];
         wire own_rd = mv_rd[own];
         wire own_last = mv_last[own];
         wire start_here = (state_q == ST_CHECK) && (state_d == ST_START);
         wire disc_here = (state_q == ST_CHECK) && (state_d == ST_DISCARD) && (ent_src_q == ch);

         // each source has its own sequencer so moves from different sources overlap
         pmd_mover u_mover
         (
            .pclk(pclk),
            .presetn(presetn),
            .pclk_en(pclk_en),
            .start((state_q == ST_START) && (ent_src_q == ch)),
            .len_dw(ent_len_q),
            .rd_en_q(mv_rd[ch]),
            .last_q(mv_last[ch])
         );

         always @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               source_channel_busy[ch] <= 1'h0;
               target_channel_busy[ch] <= 1'h0;
               src_fin_q[ch] <= 1'h0;
               owner_q[2*ch+1:2*ch] <= 2'h0;
               egress_data_in[ch*`PMD_DATA_W +: `PMD_DATA_W] <= {`PMD_DATA_W{1'h0}};
               egress_data_write_en[ch] <= 1'h0;
               egress_length_in[ch*`PMD_EGR_LEN_W +: `PMD_EGR_LEN_W] <= 16'h0000;
               egress_length_write_en[ch] <= 1'h0;
               discard_word_count[ch*`PMD_LEN_W +: `PMD_LEN_W] <= 12'h000;
               discard_strobe[ch] <= 1'h0;
            end
            else if (pclk_en)
            begin
               src_fin_q[ch] <= mv_rd[ch] & mv_last[ch];
               // set and clear never meet: a new start needs the flag already low
               if (start_here && ent_src_q == ch)
                  source_channel_busy[ch] <= 1'h1;
               else if (src_fin_q[ch])
                  source_channel_busy[ch] <= 1'h0;
               if (start_here && ent_mask_q[ch])
               begin
                  target_channel_busy[ch] <= 1'h1;
                  owner_q[2*ch+1:2*ch] <= ent_src_q;
                  egress_length_in[ch*`PMD_EGR_LEN_W +: `PMD_EGR_LEN_W] <= {4'h0, ent_len_q};
               end
               else if (egress_length_write_en[ch])
                  target_channel_busy[ch] <= 1'h0;
               // word captured at the read edge, written out the cycle after with its strobe
               egress_data_in[ch*`PMD_DATA_W +: `PMD_DATA_W] <= parser_data_out[own*`PMD_DATA_W +: `PMD_DATA_W];
               egress_data_write_en[ch] <= target_channel_busy[ch] & own_rd;
               egress_length_write_en[ch] <= target_channel_busy[ch] & own_rd & own_last;
               if (disc_here)
                  discard_word_count[ch*`PMD_LEN_W +: `PMD_LEN_W] <= ent_len_q;
               // the parser itself drops the counted words; nothing reaches the egress side
               discard_strobe[ch] <= disc_here;
            end
         end
      end
   endgenerate

   // 20 spare bits on top keep the word a full 32 bits with no silent padding
   wire [31:0] status_word = {20'h00000, target_channel_busy, source_channel_busy,
                              1'h0, decision_queue_empty_flag, state_q};

   pmd_apb_regs u_regs
   (
      .pclk(pclk),
      .presetn(presetn),
      .pclk_en(pclk_en),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .status_in(status_word),
      .fwd_pulse(fwd_pulse_q),
      .disc_pulse(disc_pulse_q),
      .run_en_q(run_en)
   );
endmodule // pmd_dispatcher

/* File: pmd_map.vh */
// constants for the packet move dispatcher: fields, states, sizes and register map
`ifndef PMD_MAP_VH
`define PMD_MAP_VH
`define PMD_NCH 4
`define PMD_DATA_W 192
`define PMD_DWORDS_PER_WORD 13'h0006
`define PMD_DWORD_ROUND 13'h0005
`define PMD_ENT_W 18
`define PMD_ENT_LEN_MSB 11
`define PMD_ENT_LEN_LSB 0
`define PMD_ENT_SRC_MSB 13
`define PMD_ENT_SRC_LSB 12
`define PMD_ENT_TGT_MSB 17
`define PMD_ENT_TGT_LSB 14
`define PMD_LEN_W 12
`define PMD_EGR_LEN_W 16
`define PMD_ST_IDLE 2'h0
`define PMD_ST_CHECK 2'h1
`define PMD_ST_START 2'h2
`define PMD_ST_DISCARD 2'h3
`define PMD_ADDR_W 8
`define PMD_REG_CTRL 8'h00
`define PMD_REG_STATUS 8'h04
`define PMD_REG_FWD_CNT 8'h08
`define PMD_REG_DISC_CNT 8'h0C
`define PMD_CTRL_RESET 1'h1
`endif

/* File: pmd_mover.v */
// per-source read sequencer: walks one packet out of a parser buffer word by word
`timescale 1ns/1ps
`include "pmd_map.vh"
module pmd_mover
(
   input wire pclk,
   input wire presetn,
   input wire pclk_en,
   input wire start,
   input wire [`PMD_LEN_W-1:0] len_dw,
   output reg rd_en_q,
   output reg last_q
);
   reg [`PMD_LEN_W:0] rem_q;
   wire [`PMD_LEN_W:0] len_x = {1'h0, len_dw};
   // ceil of 32-bit words over 192-bit words; a zero length still moves one word so the move ends
   wire [`PMD_LEN_W:0] words_raw = (len_x + `PMD_DWORD_ROUND) / `PMD_DWORDS_PER_WORD;
   wire [`PMD_LEN_W:0] words = (len_dw == 12'h000) ? 13'h0001 : words_raw;

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rem_q <= 13'h0000;
         rd_en_q <= 1'h0;
         last_q <= 1'h0;
      end
      else if (pclk_en)
      begin
         if (start)
         begin
            rem_q <= words - 13'h0001;
            rd_en_q <= 1'h1;
            last_q <= (words == 13'h0001);
         end
         else if (rd_en_q)
         begin
            if (last_q)
            begin
               rd_en_q <= 1'h0;
               last_q <= 1'h0;
            end
            else
            begin
               rem_q <= rem_q - 13'h0001;
               last_q <= (rem_q == 13'h0001);
            end
         end
      end
   end
endmodule // pmd_mover

/* File: pmd_apb_regs.v */
// apb slave holding the control, status and counter registers of the dispatcher
`timescale 1ns/1ps
`include "pmd_map.vh"
module pmd_apb_regs
(
   input wire pclk,
   input wire presetn,
   input wire pclk_en,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [`PMD_ADDR_W-1:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire [31:0] status_in,
   input wire fwd_pulse,
   input wire disc_pulse,
   output reg run_en_q
);
   reg [31:0] fwd_cnt_q;
   reg [31:0] disc_cnt_q;
   wire setup = psel & ~penable & ~pready;
   wire done = psel & penable & pready;
   wire mapped = (paddr == `PMD_REG_CTRL) || (paddr == `PMD_REG_STATUS) ||
                 (paddr == `PMD_REG_FWD_CNT) || (paddr == `PMD_REG_DISC_CNT);
   reg [31:0] rd_mux;

   always @*
   begin
      rd_mux = 32'h00000000;
      case (paddr)
         `PMD_REG_CTRL: rd_mux = {31'h00000000, run_en_q};
         `PMD_REG_STATUS: rd_mux = status_in;
         `PMD_REG_FWD_CNT: rd_mux = fwd_cnt_q;
         `PMD_REG_DISC_CNT: rd_mux = disc_cnt_q;
         default: rd_mux = 32'h00000000;
      endcase
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= 32'h00000000;
         pready <= 1'h0;
         pslverr <= 1'h0;
         run_en_q <= `PMD_CTRL_RESET;
         fwd_cnt_q <= 32'h00000000;
         disc_cnt_q <= 32'h00000000;
      end
      else if (pclk_en)
      begin
         // no wait state: pready rises in the first access cycle
         pready <= setup;
         if (setup)
         begin
            prdata <= pwrite ? 32'h00000000 : rd_mux;
            pslverr <= ~mapped;
         end
         if (done && pwrite && paddr == `PMD_REG_CTRL)
            run_en_q <= pwdata[0];
         // writing a counter clears it; a same-cycle event still counts
         if (fwd_pulse)
            fwd_cnt_q <= (done && pwrite && paddr == `PMD_REG_FWD_CNT) ? 32'h00000001 : fwd_cnt_q + 32'h00000001;
         else if (done && pwrite && paddr == `PMD_REG_FWD_CNT)
            fwd_cnt_q <= 32'h00000000;
         if (disc_pulse)
            disc_cnt_q <= (done && pwrite && paddr == `PMD_REG_DISC_CNT) ? 32'h00000001 : disc_cnt_q + 32'h00000001;
         else if (done && pwrite && paddr == `PMD_REG_DISC_CNT)
            disc_cnt_q <= 32'h00000000;
      end
   end
endmodule // pmd_apb_regs

/* File: pmd_dispatcher_properties.sv */
// port checker for the packet move dispatcher
`timescale 1ns/1ps
module pmd_chk
(
   input wire pclk,
   input wire presetn,
   input wire decision_queue_empty_flag,
   input wire decision_queue_pop,
   input wire [3:0] parser_data_read_en,
   input wire [3:0] discard_strobe,
   input wire [3:0] egress_length_almost_full,
   input wire [3:0] egress_data_write_en,
   input wire [3:0] egress_length_write_en,
   input wire [3:0] source_channel_busy,
   input wire [3:0] target_channel_busy
);
   reg [3:0] src_q;
   reg [3:0] tgt_q;
   wire [3:0] src_up = source_channel_busy & ~src_q;
   wire [3:0] tgt_up = target_channel_busy & ~tgt_q;
   always @(posedge pclk or negedge presetn)
      if (!presetn)
      begin
         src_q <= 4'h0;
         tgt_q <= 4'h0;
      end
      else
      begin
         src_q <= source_channel_busy;
         tgt_q <= target_channel_busy;
      end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_pop;
      decision_queue_pop |=> !decision_queue_pop [*2];
   endproperty
   a_pop: assert property (p_pop) else $error("pop too long");
   property p_take;
      decision_queue_pop |-> $past(decision_queue_empty_flag) == 1'h0;
   endproperty
   a_take: assert property (p_take) else $error("pop from empty");
   property p_len;
      |egress_length_write_en |-> (egress_length_write_en & ~egress_data_write_en) == 4'h0;
   endproperty
   a_len: assert property (p_len) else $error("length without word");
   property p_wr;
      |egress_data_write_en |-> $past(parser_data_read_en) != 4'h0;
   endproperty
   a_wr: assert property (p_wr) else $error("word not read");
   property p_rel;
      |egress_length_write_en |=> (target_channel_busy & $past(egress_length_write_en)) == 4'h0;
   endproperty
   a_rel: assert property (p_rel) else $error("busy held");
   property p_gate;
      |tgt_up |-> (tgt_up & $past(egress_length_almost_full)) == 4'h0;
   endproperty
   a_gate: assert property (p_gate) else $error("started while full");
   property p_disc;
      |discard_strobe |-> (discard_strobe & $past(source_channel_busy)) == 4'h0;
   endproperty
   a_disc: assert property (p_disc) else $error("discard on busy source");
   property p_dpulse;
      |discard_strobe |-> $onehot(discard_strobe) ##1 discard_strobe == 4'h0;
   endproperty
   a_dpulse: assert property (p_dpulse) else $error("bad discard strobe");
   property p_start;
      |src_up |=> (parser_data_read_en & $past(src_up)) == $past(src_up);
   endproperty
   a_start: assert property (p_start) else $error("read not started");
   c_fwd: cover property (|egress_length_write_en);
   c_disc: cover property (|discard_strobe);
   c_multi: cover property ($countones(target_channel_busy) > 1);
endmodule // pmd_chk
bind pmd_dispatcher pmd_chk chk (.pclk(pclk), .presetn(presetn),
   .decision_queue_empty_flag(decision_queue_empty_flag), .decision_queue_pop(decision_queue_pop),
   .parser_data_read_en(parser_data_read_en), .discard_strobe(discard_strobe),
   .egress_length_almost_full(egress_length_almost_full), .egress_data_write_en(egress_data_write_en),
   .egress_length_write_en(egress_length_write_en), .source_channel_busy(source_channel_busy),
   .target_channel_busy(target_channel_busy));

/* File: pmd_parser_model.sv */
// ingress parser buffer model: numbered words per channel
`timescale 1ns/1ps
module pmd_parser_model
(
   input wire pclk,
   input wire presetn,
   input wire [3:0] parser_data_read_en,
   input wire [3:0] discard_strobe,
   input wire [47:0] discard_word_count,
   output reg [767:0] parser_data_out
);
   reg [127:0] cnt_q;
   integer i;
   integer j;
   // a discard skips whole words, so the next move shows whether the drop was right
   always @(posedge pclk or negedge presetn)
      for (i = 0; i < 4; i = i + 1)
         if (!presetn)
            cnt_q[i*32+:32] <= 32'h0;
         else if (discard_strobe[i])
            cnt_q[i*32+:32] <= cnt_q[i*32+:32] + (discard_word_count[i*12+:12] + 32'h5) / 32'h6;
         else if (parser_data_read_en[i])
            cnt_q[i*32+:32] <= cnt_q[i*32+:32] + 32'h1;
   always @*
      for (j = 0; j < 4; j = j + 1)
         parser_data_out[j*192+:192] = {144'h0, j[15:0], cnt_q[j*32+:32]};
endmodule // pmd_parser_model

/* File: tb_pmd_dispatcher.sv */
// self-checking bench for the packet move dispatcher
`timescale 1ns/1ps
module tb_pmd_dispatcher;
   reg pclk, presetn, psel, penable, pwrite, push_v, err_q, decision_queue_empty_flag;
   reg [7:0] paddr;
   reg [31:0] pwdata, rd_q;
   reg [17:0] decision_entry, push_e;
   reg [3:0] egress_length_almost_full;
   wire [31:0] prdata;
   wire pready, pslverr, decision_queue_pop;
   wire [767:0] parser_data_out, egress_data_in;
   wire [3:0] parser_data_read_en, discard_strobe, egress_data_write_en;
   wire [3:0] egress_length_write_en, source_channel_busy, target_channel_busy;
   wire [47:0] discard_word_count;
   wire [63:0] egress_length_in;
   reg [191:0] eg_w [0:3][0:7];
   reg [15:0] eg_len [0:3];
   integer eg_n [0:3];
   integer ev_n, k, miscompares, checks_done;
   reg [17:0] dq [$];
   pmd_dispatcher uut (.pclk(pclk), .presetn(presetn), .pclk_en(1'h1), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .decision_queue_empty_flag(decision_queue_empty_flag), .decision_entry(decision_entry),
      .decision_queue_pop(decision_queue_pop), .parser_data_out(parser_data_out),
      .parser_data_read_en(parser_data_read_en), .discard_word_count(discard_word_count),
      .discard_strobe(discard_strobe), .egress_length_almost_full(egress_length_almost_full),
      .egress_data_in(egress_data_in), .egress_data_write_en(egress_data_write_en),
      .egress_length_in(egress_length_in), .egress_length_write_en(egress_length_write_en),
      .source_channel_busy(source_channel_busy), .target_channel_busy(target_channel_busy));
   pmd_parser_model pm (.pclk(pclk), .presetn(presetn), .parser_data_read_en(parser_data_read_en),
      .discard_strobe(discard_strobe), .discard_word_count(discard_word_count), .parser_data_out(parser_data_out));
   initial
   begin
      pclk = 1'h0;
      forever #25 pclk = ~pclk;
   end
   // queue head falls through; egress writes logged as they are sampled
   always @(posedge pclk)
   begin
      if (decision_queue_pop) dq.pop_front();
      if (push_v) dq.push_back(push_e);
      decision_queue_empty_flag <= (dq.size() == 0);
      decision_entry <= (dq.size() == 0) ? 18'h0 : dq[0];
      ev_n = ev_n + ((|egress_length_write_en) | (|discard_strobe));
      for (k = 0; k < 4; k = k + 1)
      begin
         if (egress_data_write_en[k]) eg_w[k][eg_n[k]] = egress_data_in[k*192+:192];
         eg_n[k] = eg_n[k] + egress_data_write_en[k];
         if (egress_length_write_en[k]) eg_len[k] = egress_length_in[k*16+:16];
      end
   end
   function [191:0] w(input [15:0] c, input [31:0] n);
      w = {144'h0, c, n};
   endfunction
   task report_and_stop;
   begin
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   end
   endtask
   task chk(input [191:0] got, input [191:0] exp);
   begin
      checks_done = checks_done + 1;
      if (got !== exp)
      begin
         miscompares = miscompares + 1;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   end
   endtask
   task apb(input wr, input [7:0] a, input [31:0] d);
      integer n;
   begin
      n = 0;
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      @(posedge pclk);
      while (pready !== 1'h1 && n < 20)
      begin
         @(posedge pclk);
         n = n + 1;
      end
      rd_q = prdata;
      err_q = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
      if (n == 20) miscompares = miscompares + 1;
      if (n == 20) report_and_stop;
   end
   endtask
   task push(input [17:0] e);
   begin
      push_e <= e;
      push_v <= 1'h1;
      @(posedge pclk);
      push_v <= 1'h0;
      @(posedge pclk);
   end
   endtask
   task wait_ev(input integer t);
      integer n;
   begin
      n = 0;
      while (ev_n < t && n < 300)
      begin
         @(posedge pclk);
         n = n + 1;
      end
      if (n == 300)
      begin
         miscompares = miscompares + 1;
         report_and_stop;
      end
      else
         repeat (2) @(posedge pclk);
   end
   endtask
   initial
   begin
      presetn = 1'h0;
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      push_v = 1'h0;
      push_e = 18'h0;
      egress_length_almost_full = 4'h0;
      ev_n = 0;
      miscompares = 0;
      checks_done = 0;
      for (k = 0; k < 4; k = k + 1) eg_n[k] = 0;
      repeat (12) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      apb(1'h0, 8'h00, 32'h0);
      chk(rd_q, 32'h1);
      chk(err_q, 1'h0);
      apb(1'h0, 8'h04, 32'h0);
      chk(rd_q, 32'h4);
      apb(1'h1, 8'h10, 32'h5);
      chk(err_q, 1'h1);
      push(18'h0400C);
      wait_ev(1);
      chk(eg_w[0][0], w(0, 0));
      chk(eg_w[0][1], w(0, 1));
      chk(eg_n[0], 2);
      chk(eg_len[0], 16'h000C);
      chk(source_channel_busy | target_channel_busy, 4'h0);
      push(18'h2A007);
      wait_ev(2);
      chk(eg_w[1][0], w(2, 0));
      chk(eg_w[3][1], w(2, 1));
      chk(eg_len[3], 16'h0007);
      egress_length_almost_full <= 4'h2;
      push(18'h0B006);
      repeat (20) @(posedge pclk);
      chk(target_channel_busy, 4'h0);
      chk(source_channel_busy, 4'h0);
      apb(1'h0, 8'h04, 32'h0);
      chk(rd_q, 32'h5);
      egress_length_almost_full <= 4'h0;
      wait_ev(3);
      chk(eg_w[1][2], w(3, 0));
      push(18'h0100D);
      wait_ev(4);
      chk(discard_word_count[23:12], 12'h00D);
      chk(eg_n[2], 0);
      push(18'h11001);
      wait_ev(5);
      chk(eg_w[2][0], w(1, 3));
      push(18'h04006);
      push(18'h00006);
      push(18'h04001);
      wait_ev(8);
      chk(eg_w[0][2], w(0, 2));
      chk(eg_w[0][3], w(0, 4));
      apb(1'h1, 8'h00, 32'h0);
      push(18'h04001);
      repeat (10) @(posedge pclk);
      chk(decision_queue_empty_flag, 1'h0);
      apb(1'h0, 8'h04, 32'h0);
      chk(rd_q, 32'h0);
      apb(1'h1, 8'h00, 32'h1);
      wait_ev(9);
      chk(eg_w[0][4], w(0, 5));
      // seven forwarded and two discarded decisions over the whole run
      apb(1'h0, 8'h08, 32'h0);
      chk(rd_q, 32'h7);
      apb(1'h0, 8'h0C, 32'h0);
      chk(rd_q, 32'h2);
      apb(1'h1, 8'h08, 32'h0);
      apb(1'h0, 8'h08, 32'h0);
      chk(rd_q, 32'h0);
      report_and_stop;
   end
endmodule // tb_pmd_dispatcher
